// File: common/pmsq_pkg.sv
// Constants for the camera power sequencer and protection controller
// Behaviour
// - Channel 7 boost when topology pin high
// - Boost: isolation gate follows control bit
// - Channel 7 body-diode until above main rail
// - Main rail regulator always enabled
// - Main rail skip when request low, else sync
// - Backup LDO follows its enable bit
// - Backup LDO held off 30 us after rail-good
// - USB LDO held off 1.03 ms after rail-good
// - USB LDO follows its enable pin
// - LCD LDO follows its enable bit
// - Thermal trip stops all but main rail
// - Short-circuit trip stops all but main rail
// - Backlight overvoltage latches, disables, discharges
// - Backlight overvoltage cleared by request low
// - Other overvoltage suppresses switching while present
// - Backlight overcurrent halts switching, discharges
// - Host reset and rail-good from monitors
// - Soft-start done flag from channel 3
// - Soft-start done enables remaining channels
// - 544 PWM pulses, then channel 3 first
// - Defaults enable everything without sub-processor
package pmsq_pkg;

  localparam int unsigned NUM_CH         = 7;
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned BACKUP_DLY_NS  = 30000;
  localparam int unsigned USB_DLY_NS     = 1030000;
  localparam int unsigned BACKUP_DLY_CYC =
    (BACKUP_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned USB_DLY_CYC    =
    (USB_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_PULSES  = 544;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TRIP   = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_BACKUP_EN = 0;
  localparam int unsigned CTRL_LCD_EN    = 1;
  localparam int unsigned CTRL_ISO_SW    = 2;
  localparam int unsigned CTRL_CH_LSB    = 4;
  localparam int unsigned CTRL_W         = 11;
  localparam logic [10:0] CTRL_RESET     = 11'h7F7;

  // Status register fields
  localparam int unsigned ST_RAIL_GOOD  = 0;
  localparam int unsigned ST_MAIN_SYNC  = 1;
  localparam int unsigned ST_SS_DONE    = 2;
  localparam int unsigned ST_BL_OVP     = 3;
  localparam int unsigned ST_BACKUP_ON  = 4;
  localparam int unsigned ST_USB_ON     = 5;
  localparam int unsigned ST_LCD_ON     = 6;
  localparam int unsigned ST_FAULT_STOP = 7;
  localparam int unsigned ST_SETTLED    = 8;
  localparam int unsigned ST_W          = 9;

  // Trip register fields
  localparam int unsigned TRIP_THERMAL = 0;
  localparam int unsigned TRIP_SCP_LSB = 1;
  localparam int unsigned TRIP_OVP_LSB = 8;
  localparam int unsigned TRIP_OCP     = 12;
  localparam int unsigned TRIP_W       = 13;

  // Overvoltage inputs: channels 2, 3, 6, 7
  localparam int unsigned OVP_CH2 = 0;
  localparam int unsigned OVP_CH3 = 1;
  localparam int unsigned OVP_CH6 = 2;
  localparam int unsigned OVP_CH7 = 3;

  // Channel index inside enable vectors (channel n at n-1)
  localparam int unsigned CH3_IDX = 2;
  localparam int unsigned CH6_IDX = 5;
  localparam int unsigned CH7_IDX = 6;

  typedef enum logic [2:0] {
    PMSQ_SKIP,
    PMSQ_SETTLE,
    PMSQ_CH3_START,
    PMSQ_ALL_RUN,
    PMSQ_FAULT_STOP
  } pmsq_state_t;

endpackage : pmsq_pkg

// File: design/pmsq_ctrl.sv
// Power sequencer, protection logic and APB register slave
//
// Local design decisions: the APB slave port and the register addresses.
module pmsq_ctrl #(
  parameter int unsigned USB_DLY_CYCLES = pmsq_pkg::USB_DLY_CYC,
  parameter int unsigned SETTLE_PULSES  = pmsq_pkg::SETTLE_PULSES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog monitors and pins
  input  wire logic        aux_topology_select,
  input  wire logic        power_on_request,
  input  wire logic        usb_ldo_enable_pin,
  input  wire logic        main_rail_sense,
  input  wire logic        aux_output_sense,
  input  wire logic        core_ldo_sense,
  input  wire logic        boost5_softstart_pin,
  input  wire logic        pwm_pulse,
  input  wire logic        thermal_trip,
  input  wire logic [6:0]  short_circuit_trip,
  input  wire logic [3:0]  overvoltage_trip,
  input  wire logic        overcurrent_trip,
  // Regulator controls
  output logic             aux_boost_mode,
  output logic             aux_isolation_gate,
  output logic             aux_sync_rect_en,
  output logic             main_reg_en,
  output logic             main_sync_mode,
  output logic [6:0]       ch_enable,
  output logic [6:0]       ch_switch_en,
  output logic             backlight_discharge_node,
  output logic             backup_ldo_en,
  output logic             usb_ldo_en,
  output logic             lcd_ldo_en,
  output logic             host_reset_n,
  output logic             rail_good,
  output logic             boost5_softstart_done
);

  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  // Registers
  logic [pmsq_pkg::CTRL_W-1:0] ctrl_q;
  logic [pmsq_pkg::TRIP_W-1:0] trip_q;
  logic [pmsq_pkg::TRIP_W-1:0] trip_d;
  logic                        bl_ovp_q;
  logic                        aux_up_q;
  pmsq_pkg::pmsq_state_t       state_q;
  pmsq_pkg::pmsq_state_t       state_d;

  // Output flops
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        aux_boost_q;
  logic        aux_iso_q;
  logic        aux_sync_q;
  logic        main_sync_q;
  logic [6:0]  ch_en_q;
  logic [6:0]  ch_sw_q;
  logic        discharge_q;
  logic        backup_q;
  logic        usb_q;
  logic        lcd_q;
  logic        host_rst_n_q;
  logic        rail_good_q;
  logic        ss_done_q;
  logic        main_en_q;

  // Bus decode
  wire hit_ctrl   = reg_hit(paddr, pmsq_pkg::OFF_CTRL);
  wire hit_status = reg_hit(paddr, pmsq_pkg::OFF_STATUS);
  wire hit_trip   = reg_hit(paddr, pmsq_pkg::OFF_TRIP);
  wire hit_any    = hit_ctrl | hit_status | hit_trip;
  wire access     = psel & penable;
  wire complete   = access & pready_q;
  wire ctrl_wr    = complete & pwrite & hit_ctrl;

  // Protection conditions
  wire any_scp    = |short_circuit_trip;
  wire fault_trip = thermal_trip | any_scp;
  wire bl_ovp_in  = overvoltage_trip[pmsq_pkg::OVP_CH6];
  wire bl_ovp_set = bl_ovp_in;
  wire bl_ovp_clr = !power_on_request;

  // Delay timers
  wire settled;
  wire backup_ok;
  wire usb_ok;
  wire settle_run = (state_q == pmsq_pkg::PMSQ_SETTLE);

  pmsq_delay_timer #(
    .W     (10),
    .COUNT (SETTLE_PULSES)
  ) u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .run     (settle_run),
    .tick    (pwm_pulse),
    .done    (settled)
  );

  pmsq_delay_timer #(
    .W     (10),
    .COUNT (pmsq_pkg::BACKUP_DLY_CYC)
  ) u_backup_ldo_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .run     (rail_good_q),
    .tick    (1'b1),
    .done    (backup_ok)
  );

  pmsq_delay_timer #(
    .W     (16),
    .COUNT (USB_DLY_CYCLES)
  ) u_usb_ldo_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .run     (rail_good_q),
    .tick    (1'b1),
    .done    (usb_ok)
  );

  wire running  = (state_q == pmsq_pkg::PMSQ_SETTLE)
               || (state_q == pmsq_pkg::PMSQ_CH3_START)
               || (state_q == pmsq_pkg::PMSQ_ALL_RUN);
  wire stopped  = (state_q == pmsq_pkg::PMSQ_FAULT_STOP) || fault_trip;
  wire ch3_on   = (state_q == pmsq_pkg::PMSQ_CH3_START)
               || (state_q == pmsq_pkg::PMSQ_ALL_RUN);
  wire all_on   = (state_q == pmsq_pkg::PMSQ_ALL_RUN);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      pmsq_pkg::PMSQ_SKIP: begin
        if (power_on_request && rail_good_q) begin
          state_d = pmsq_pkg::PMSQ_SETTLE;
        end
      end
      pmsq_pkg::PMSQ_SETTLE: begin
        if (settled) begin
          state_d = pmsq_pkg::PMSQ_CH3_START;
        end
      end
      pmsq_pkg::PMSQ_CH3_START: begin
        if (ss_done_q) begin
          state_d = pmsq_pkg::PMSQ_ALL_RUN;
        end
      end
      pmsq_pkg::PMSQ_ALL_RUN: begin
        state_d = pmsq_pkg::PMSQ_ALL_RUN;
      end
      pmsq_pkg::PMSQ_FAULT_STOP: begin
        // Held until the sub-processor drops its request or rail-good falls
        state_d = pmsq_pkg::PMSQ_FAULT_STOP;
      end
      default: begin
        state_d = pmsq_pkg::PMSQ_SKIP;
      end
    endcase
    if (running && fault_trip) begin
      state_d = pmsq_pkg::PMSQ_FAULT_STOP;
    end
    if (!power_on_request || !rail_good_q) begin
      state_d = pmsq_pkg::PMSQ_SKIP;
    end
  end

  // Channel enables from sequence and control bits
  wire [6:0] ch_sw_bits = ctrl_q[pmsq_pkg::CTRL_CH_LSB +: 7];
  wire [6:0] ch_en_d;
  wire [6:0] ch_sw_d;
  wire [6:0] ovp_by_ch;

  assign ovp_by_ch = {overvoltage_trip[pmsq_pkg::OVP_CH7],
                      3'b000,
                      overvoltage_trip[pmsq_pkg::OVP_CH3],
                      overvoltage_trip[pmsq_pkg::OVP_CH2],
                      1'b0};

  genvar g;
  generate
    for (g = 0; g < pmsq_pkg::NUM_CH; g++) begin : g_ch
      if (g == pmsq_pkg::CH3_IDX) begin : g_first
        assign ch_en_d[g] = ch3_on & ch_sw_bits[g] & !stopped;
      end else if (g == pmsq_pkg::CH6_IDX) begin : g_bl
        assign ch_en_d[g] = all_on & ch_sw_bits[g] & !stopped
                          & !bl_ovp_q & !bl_ovp_in;
      end else begin : g_rest
        assign ch_en_d[g] = all_on & ch_sw_bits[g] & !stopped;
      end
      if (g == pmsq_pkg::CH6_IDX) begin : g_bl_sw
        assign ch_sw_d[g] = ch_en_d[g] & !overcurrent_trip;
      end else begin : g_sw
        assign ch_sw_d[g] = ch_en_d[g] & !ovp_by_ch[g];
      end
    end
  endgenerate

  // Trips and LDO gating
  assign trip_d = {overcurrent_trip,
                   overvoltage_trip,
                   short_circuit_trip,
                   thermal_trip};

  wire ldo_allowed = rail_good_q && !stopped;
  wire backup_d = ldo_allowed && backup_ok
                && ctrl_q[pmsq_pkg::CTRL_BACKUP_EN];
  wire usb_d    = ldo_allowed && usb_ok && usb_ldo_enable_pin;
  wire lcd_d    = ldo_allowed && all_on
                && ctrl_q[pmsq_pkg::CTRL_LCD_EN];
  wire boost_d  = aux_topology_select;
  wire aux_en_d = ch_en_d[pmsq_pkg::CH7_IDX];
  wire aux_up_d = aux_en_d && (aux_up_q || aux_output_sense);

  // Read mux
  wire [pmsq_pkg::ST_W-1:0] status_w;
  assign status_w[pmsq_pkg::ST_RAIL_GOOD]  = rail_good_q;
  assign status_w[pmsq_pkg::ST_MAIN_SYNC]  = main_sync_q;
  assign status_w[pmsq_pkg::ST_SS_DONE]    = ss_done_q;
  assign status_w[pmsq_pkg::ST_BL_OVP]     = bl_ovp_q;
  assign status_w[pmsq_pkg::ST_BACKUP_ON]  = backup_q;
  assign status_w[pmsq_pkg::ST_USB_ON]     = usb_q;
  assign status_w[pmsq_pkg::ST_LCD_ON]     = lcd_q;
  assign status_w[pmsq_pkg::ST_FAULT_STOP] =
    (state_q == pmsq_pkg::PMSQ_FAULT_STOP);
  assign status_w[pmsq_pkg::ST_SETTLED]    = ch3_on;

  wire [31:0] rdata_w =
      hit_ctrl   ? {21'h0, ctrl_q}   :
      hit_status ? {23'h0, status_w} :
      hit_trip   ? {19'h0, trip_q}   : 32'h00000000;

  // Bus slave: one wait cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (clk_en) begin
      pready_q  <= access & !pready_q;
      pslverr_q <= access & !pready_q & !hit_any;
      if (access && !pready_q && !pwrite) begin
        prdata_q <= rdata_w;
      end
    end
  end

  // Control register; reset values enable every channel and the backup and LCD LDOs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pmsq_pkg::CTRL_RESET;
    end else if (clk_en && ctrl_wr) begin
      ctrl_q <= pwdata[pmsq_pkg::CTRL_W-1:0];
    end
  end

  // Sticky trip record, backlight latch, sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_q   <= '0;
      bl_ovp_q <= 1'b0;
      aux_up_q <= 1'b0;
      state_q  <= pmsq_pkg::PMSQ_SKIP;
    end else if (clk_en) begin
      trip_q   <= trip_q | trip_d;
      if (bl_ovp_set) begin
        bl_ovp_q <= 1'b1;
      end else if (bl_ovp_clr) begin
        bl_ovp_q <= 1'b0;
      end
      aux_up_q <= aux_up_d;
      state_q  <= state_d;
    end
  end

  // Regulator control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_boost_q  <= 1'b0;
      aux_iso_q    <= 1'b0;
      aux_sync_q   <= 1'b0;
      main_sync_q  <= 1'b0;
      ch_en_q      <= 7'h00;
      ch_sw_q      <= 7'h00;
      discharge_q  <= 1'b0;
      backup_q     <= 1'b0;
      usb_q        <= 1'b0;
      lcd_q        <= 1'b0;
      host_rst_n_q <= 1'b0;
      rail_good_q  <= 1'b0;
      ss_done_q    <= 1'b0;
      main_en_q    <= 1'b1;
    end else if (clk_en) begin
      aux_boost_q  <= boost_d;
      aux_iso_q    <= boost_d & ctrl_q[pmsq_pkg::CTRL_ISO_SW];
      aux_sync_q   <= aux_en_d & aux_up_q;
      main_sync_q  <= power_on_request;
      ch_en_q      <= ch_en_d;
      ch_sw_q      <= ch_sw_d;
      discharge_q  <= bl_ovp_q | bl_ovp_in | overcurrent_trip;
      backup_q     <= backup_d;
      usb_q        <= usb_d;
      lcd_q        <= lcd_d;
      host_rst_n_q <= core_ldo_sense;
      rail_good_q  <= main_rail_sense;
      ss_done_q    <= boost5_softstart_pin & ch3_on;
      main_en_q    <= 1'b1;
    end
  end

  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign aux_boost_mode           = aux_boost_q;
  assign aux_isolation_gate       = aux_iso_q;
  assign aux_sync_rect_en         = aux_sync_q;
  assign main_reg_en              = main_en_q;
  assign main_sync_mode           = main_sync_q;
  assign ch_enable                = ch_en_q;
  assign ch_switch_en             = ch_sw_q;
  assign backlight_discharge_node = discharge_q;
  assign backup_ldo_en            = backup_q;
  assign usb_ldo_en               = usb_q;
  assign lcd_ldo_en               = lcd_q;
  assign host_reset_n             = host_rst_n_q;
  assign rail_good                = rail_good_q;
  assign boost5_softstart_done    = ss_done_q;

endmodule : pmsq_ctrl

// File: design/pmsq_delay_timer.sv
// Restartable delay counter that raises done after a number of ticks
module pmsq_delay_timer #(
  parameter int unsigned W     = 16,
  parameter int unsigned COUNT = 600
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic run,
  input  wire logic tick,
  output logic      done
);

  logic [W-1:0] cnt_q;
  logic         done_q;
  wire          last = (cnt_q == W'(COUNT - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_q  <= '0;
        done_q <= 1'b0;
      end else if (tick && !done_q) begin
        if (last) begin
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign done = done_q;

endmodule : pmsq_delay_timer

// File: testbench/pmsq_ctrl_props.sv
// Checker for the power sequencer and protection controller
module pmsq_ctrl_props #(
  parameter int unsigned USB_DLY_CYCLES = pmsq_pkg::USB_DLY_CYC
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       power_on_request,
  input wire logic       main_rail_sense,
  input wire logic       aux_output_sense,
  input wire logic       core_ldo_sense,
  input wire logic       aux_topology_select,
  input wire logic       boost5_softstart_pin,
  input wire logic       thermal_trip,
  input wire logic [6:0] short_circuit_trip,
  input wire logic [3:0] overvoltage_trip,
  input wire logic       overcurrent_trip,
  input wire logic       aux_isolation_gate,
  input wire logic       aux_sync_rect_en,
  input wire logic       main_sync_mode,
  input wire logic [6:0] ch_enable,
  input wire logic [6:0] ch_switch_en,
  input wire logic       backlight_discharge_node,
  input wire logic       backup_ldo_en,
  input wire logic       usb_ldo_en,
  input wire logic       host_reset_n,
  input wire logic       rail_good,
  input wire logic       boost5_softstart_done
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BACKUP_MIN = pmsq_pkg::BACKUP_DLY_CYC - 3;
  localparam int USB_MIN    = USB_DLY_CYCLES - 3;
  logic [15:0] good_cnt_q;
  logic [15:0] good_cnt_d;
  // Cycles of continuous rail-good, saturating
  assign good_cnt_d = !rail_good ? 16'h0000 :
                      (&good_cnt_q ? good_cnt_q : good_cnt_q + 16'h0001);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      good_cnt_q <= 16'h0000;
    end else begin
      good_cnt_q <= good_cnt_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence trip_s;
    thermal_trip || (|short_circuit_trip);
  endsequence
  sequence ss_ready_s;
    ch_enable[2] && boost5_softstart_pin && power_on_request;
  endsequence
  iso_gate_a: assert property ((!aux_topology_select)[*2] |->
    !aux_isolation_gate) else $error("isolation gate on in buck mode");
  sync_rect_a: assert property ($rose(aux_sync_rect_en) |->
    $past(aux_output_sense) || $past(aux_output_sense, 2))
    else $error("sync rectification before output above main rail");
  main_skip_a: assert property ((!power_on_request)[*2] |->
    !main_sync_mode) else $error("main rail not in skip mode");
  backup_dly_a: assert property (backup_ldo_en && rail_good |->
    good_cnt_q >= BACKUP_MIN) else $error("backup LDO on too early");
  usb_dly_a: assert property (usb_ldo_en && rail_good |->
    good_cnt_q >= USB_MIN) else $error("USB LDO on too early");
  fault_stop_a: assert property (trip_s |-> ##[1:3]
    (ch_enable == 7'h00 && !backup_ldo_en && !usb_ldo_en))
    else $error("channels still on after fault trip");
  bl_latch_a: assert property (overvoltage_trip[2] && power_on_request
    ##1 power_on_request[*3] |-> backlight_discharge_node && !ch_switch_en[5])
    else $error("backlight overvoltage not latched");
  bl_clear_a: assert property ((!power_on_request && !overcurrent_trip
    && !overvoltage_trip[2])[*3] |-> !backlight_discharge_node)
    else $error("backlight discharge not released");
  ovp_hold_a: assert property ((overvoltage_trip[0])[*3] |->
    !ch_switch_en[1]) else $error("channel 2 switching during overvoltage");
  ocp_halt_a: assert property (overcurrent_trip[*3] |->
    backlight_discharge_node && !ch_switch_en[5])
    else $error("backlight switching during overcurrent");
  host_rst_a: assert property ($stable(core_ldo_sense)[*2] |->
    host_reset_n == core_ldo_sense) else $error("host reset mismatch");
  rail_good_a: assert property ($stable(main_rail_sense)[*2] |->
    rail_good == main_rail_sense) else $error("rail good mismatch");
  rail_lost_a: assert property ((!main_rail_sense)[*3] |->
    !backup_ldo_en && !usb_ldo_en) else $error("LDO on without rail");
  ss_flag_a: assert property (ss_ready_s ##1 !thermal_trip |->
    ##[0:2] boost5_softstart_done) else $error("soft-start flag missing");
endmodule : pmsq_ctrl_props

bind pmsq_ctrl pmsq_ctrl_props #(.USB_DLY_CYCLES(USB_DLY_CYCLES))
  i_pmsq_ctrl_props (.pclk, .presetn, .power_on_request, .main_rail_sense,
  .aux_output_sense, .core_ldo_sense, .aux_topology_select,
  .boost5_softstart_pin, .thermal_trip, .short_circuit_trip,
  .overvoltage_trip, .overcurrent_trip, .aux_isolation_gate,
  .aux_sync_rect_en, .main_sync_mode, .ch_enable, .ch_switch_en,
  .backlight_discharge_node, .backup_ldo_en, .usb_ldo_en, .host_reset_n,
  .rail_good, .boost5_softstart_done);

// File: testbench/pmsq_subproc.sv
// Sub-processor model that raises and drops the power-on request
module pmsq_subproc #(
  parameter int unsigned RESP_DLY = 2
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [6:0] ch_enable,
  output logic            power_on_request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       up_q;
  logic       drop_q;
  logic [3:0] wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q <= 1'b0;
      drop_q <= 1'b0;
      wait_q <= 4'h0;
      power_on_request <= 1'b0;
    end else begin
      if (!start) begin
        up_q <= 1'b0;
        drop_q <= 1'b0;
        wait_q <= 4'h0;
      end else if (up_q && !(&ch_enable[1:0])) begin
        // Processor rails lost: give up the request after a delay
        if (wait_q == RESP_DLY[3:0]) begin
          drop_q <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else if (&ch_enable[1:0]) begin
        up_q <= 1'b1;
      end
      power_on_request <= start && !drop_q;
    end
  end
endmodule : pmsq_subproc

// File: testbench/tb.sv
// Self-checking testbench for the power sequencer controller
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        aux_topology_select, power_on_request, usb_ldo_enable_pin;
  logic        main_rail_sense, aux_output_sense, core_ldo_sense, start;
  logic        boost5_softstart_pin, pwm_pulse, thermal_trip, overcurrent_trip;
  logic [6:0]  short_circuit_trip, ch_enable, ch_switch_en;
  logic [3:0]  overvoltage_trip;
  logic        aux_boost_mode, aux_isolation_gate, aux_sync_rect_en, err;
  logic        main_reg_en, main_sync_mode, backlight_discharge_node;
  logic        backup_ldo_en, usb_ldo_en, lcd_ldo_en, host_reset_n;
  logic        rail_good, boost5_softstart_done;
  int          mismatches, checks, cycles;
  // Rows: {topology, core good, main good, boost, iso gate, reset_n, good}
  localparam logic [6:0] ROWS [4] = '{7'h00, 7'h4C, 7'h33, 7'h7F};

  pmsq_ctrl #(.USB_DLY_CYCLES(50), .SETTLE_PULSES(4)) i_pmsq_ctrl (.pclk,
    .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .aux_topology_select, .power_on_request,
    .usb_ldo_enable_pin, .main_rail_sense, .aux_output_sense, .core_ldo_sense,
    .boost5_softstart_pin, .pwm_pulse, .thermal_trip, .short_circuit_trip,
    .overvoltage_trip, .overcurrent_trip, .aux_boost_mode, .aux_isolation_gate,
    .aux_sync_rect_en, .main_reg_en, .main_sync_mode, .ch_enable,
    .ch_switch_en, .backlight_discharge_node, .backup_ldo_en, .usb_ldo_en,
    .lcd_ldo_en, .host_reset_n, .rail_good, .boost5_softstart_done);
  pmsq_subproc #(.RESP_DLY(2)) i_pmsq_subproc (.pclk, .presetn, .start,
    .ch_enable, .power_on_request);

  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wdata);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulses(input int n);
    repeat (n) begin
      pwm_pulse <= 1'b1;
      @(posedge pclk);
      pwm_pulse <= 1'b0;
      @(posedge pclk);
    end
  endtask : pulses

  initial begin
    {pclk, presetn, psel, penable, pwrite, start, pwm_pulse} = '0;
    {aux_topology_select, usb_ldo_enable_pin, main_rail_sense} = '0;
    {aux_output_sense, core_ldo_sense, boost5_softstart_pin} = '0;
    {thermal_trip, overcurrent_trip, short_circuit_trip} = '0;
    {paddr, pwdata, overvoltage_trip} = '0;
    clk_en = 1'b1;
    repeat (6) @(posedge pclk);
    chk("reset outs", 32'h100, {23'h0, main_reg_en, ch_enable, rail_good});
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl default", 32'h7F7, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    foreach (ROWS[i]) begin
      {aux_topology_select, core_ldo_sense, main_rail_sense} <= ROWS[i][6:4];
      repeat (3) @(posedge pclk);
      chk("row", {28'h0, ROWS[i][3:0]}, {28'h0, aux_boost_mode,
        aux_isolation_gate, host_reset_n, rail_good});
    end
    main_rail_sense <= 1'b0;
    repeat (3) @(posedge pclk);
    main_rail_sense <= 1'b1;
    usb_ldo_enable_pin <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("usb early", 32'h0, {31'h0, usb_ldo_en});
    repeat (15) @(posedge pclk);
    chk("usb on", 32'h1, {31'h0, usb_ldo_en});
    repeat (525) @(posedge pclk);
    chk("backup early", 32'h0, {31'h0, backup_ldo_en});
    repeat (30) @(posedge pclk);
    chk("backup on", 32'h1, {31'h0, backup_ldo_en});
    usb_ldo_enable_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("usb off", 32'h0, {31'h0, usb_ldo_en});
    start <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("sync mode", 32'h1, {31'h0, main_sync_mode});
    pulses(3);
    chk("before ch3", 32'h0, {25'h0, ch_enable});
    pulses(1);
    repeat (3) @(posedge pclk);
    chk("ch3 first", 32'h4, {25'h0, ch_enable});
    boost5_softstart_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("all run", 32'h1FF, {23'h0, boost5_softstart_done, lcd_ldo_en,
      ch_enable});
    chk("body diode", 32'h0, {31'h0, aux_sync_rect_en});
    aux_output_sense <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("sync rect", 32'h1, {31'h0, aux_sync_rect_en});
    overvoltage_trip <= 4'h1;
    repeat (3) @(posedge pclk);
    chk("ovp ch2", 32'h7D, {25'h0, ch_switch_en});
    overvoltage_trip <= 4'h0;
    overcurrent_trip <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("ocp", 32'hDF, {24'h0, backlight_discharge_node, ch_switch_en});
    overcurrent_trip <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("resume", 32'h7F, {24'h0, backlight_discharge_node, ch_switch_en});
    overvoltage_trip <= 4'h4;
    repeat (2) @(posedge pclk);
    overvoltage_trip <= 4'h0;
    repeat (4) @(posedge pclk);
    chk("bl latch", 32'hDF, {24'h0, backlight_discharge_node, ch_switch_en});
    apb(1'b1, 8'h00, 32'h7F0);
    repeat (2) @(posedge pclk);
    chk("ctrl off", 32'h0, {29'h0, lcd_ldo_en, backup_ldo_en,
      aux_isolation_gate});
    apb(1'b1, 8'h00, 32'h7F7);
    repeat (2) @(posedge pclk);
    chk("ctrl on", 32'h7, {29'h0, lcd_ldo_en, backup_ldo_en,
      aux_isolation_gate});
    apb(1'b0, 8'h04, 32'h0);
    chk("status", 32'h15F, rd);
    thermal_trip <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("thermal", 32'h200, {22'h0, main_reg_en, lcd_ldo_en,
      backup_ldo_en, ch_enable});
    thermal_trip <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("fault exit", 32'h0, {29'h0, power_on_request, main_sync_mode,
      backlight_discharge_node});
    apb(1'b0, 8'h08, 32'h0);
    chk("trip flags", 32'h1501, rd);
    start <= 1'b0;
    repeat (2) @(posedge pclk);
    start <= 1'b1;
    repeat (3) @(posedge pclk);
    pulses(4);
    repeat (6) @(posedge pclk);
    chk("restart", 32'h7F, {25'h0, ch_enable});
    short_circuit_trip <= 7'h10;
    repeat (3) @(posedge pclk);
    chk("short", 32'h0, {25'h0, ch_enable});
    short_circuit_trip <= 7'h00;
    apb(1'b0, 8'h08, 32'h0);
    chk("trip sticky", 32'h1521, rd);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    chk("trip cleared", 32'h0, rd);
    close_out();
  end
endmodule : tb
